// File: hdl/lcd_ram_command_decoder.sv
// Device end: command decoder, RAM addressing and read latch
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Operation
// - B8H..BBH load page address
// - Page change leaves display untouched
// - Bit7 clear loads column address
// - Data write advances column by one, data read only outside RMW
// - Column saturates at 80, page untouched
// - Status read returns busy/adc/off/reset
// - Busy refuses commands while executing
// - ADC bit reports segment mapping
// - Off flag inverts display command
// - Reset flag high while resetting
// - Data write stores then increments
// - Data read returns latch, refills, increments outside RMW
// - Host dummy-reads after column load
// - A0H/A1H set segment mapping
// - A4H/A5H static drive
// - A8H/A9H select duty, host uses 1/32
// - E0H saves column, enters RMW
// - Host avoids column set in RMW
// - EEH ends RMW, restores column
// - E2H clears start line, page 3
// - System asserts reset pin at power-up
// - AEH/AFH display off/on
// - 110xxxxx loads start line
module lcd_ram_command_decoder (
    // Clock, reset, enable
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // Host bus
    lcd_bus_if.device bus,
    // Display settings
    output logic [4:0] start_line_out,
    output logic adc_out,
    output logic display_on_out,
    output logic static_drive_out,
    output logic duty_32_out,
    output logic busy_out
);
    logic [7:0] ram_q [lcd_cmd_pkg::NUM_PAGES*lcd_cmd_pkg::NUM_COLS];
    logic [1:0] page_q;
    logic [6:0] col_q;
    logic [6:0] col_saved_q;
    logic rmw_q;
    logic [7:0] latch_q;
    logic [7:0] dout_q;
    logic oe_q;
    logic [2:0] rst_cnt_q;
    logic busy_q;
    logic [8:0] ram_addr;
    logic [6:0] col_inc;
    logic cmd_wr;
    logic dat_wr;
    logic dat_rd;
    logic st_rd;
    logic [7:0] cmd;
    logic in_reset;

    assign cmd = bus.host_data;
    assign in_reset = rst_cnt_q != 3'h0;
    assign cmd_wr = ce_in && bus.strobe && !bus.register_select && !bus.read_not_write && !busy_q;
    assign dat_wr = ce_in && bus.strobe && bus.register_select && !bus.read_not_write;
    assign dat_rd = ce_in && bus.strobe && bus.register_select && bus.read_not_write;
    assign st_rd = ce_in && bus.strobe && !bus.register_select && bus.read_not_write;
    assign ram_addr = 9'(page_q * lcd_cmd_pkg::NUM_COLS) + 9'(col_q);
    assign col_inc = (col_q >= lcd_cmd_pkg::COL_LIMIT) ? lcd_cmd_pkg::COL_LIMIT : col_q + 7'h01;
    assign busy_out = busy_q;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_cnt_q <= 3'h0;
            busy_q <= 1'b0;
        end else if (ce_in) begin
            if (cmd_wr && cmd == lcd_cmd_pkg::OP_SWRESET) begin
                rst_cnt_q <= lcd_cmd_pkg::SWRESET_CNT;
                busy_q <= 1'b1;
            end else if (in_reset) begin
                rst_cnt_q <= rst_cnt_q - 3'h1;
                busy_q <= rst_cnt_q != 3'h1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            page_q <= lcd_cmd_pkg::PAGE_HW_RESET;
            start_line_out <= lcd_cmd_pkg::LINE_RESET;
        end else if (ce_in && cmd_wr) begin
            if (cmd[7:2] == lcd_cmd_pkg::OP_PAGE_HI) begin
                page_q <= cmd[1:0];
            end
            if (cmd[7:5] == lcd_cmd_pkg::OP_LINE_HI) begin
                start_line_out <= cmd[4:0];
            end
            if (cmd == lcd_cmd_pkg::OP_SWRESET) begin
                page_q <= lcd_cmd_pkg::PAGE_RESET;
                start_line_out <= lcd_cmd_pkg::LINE_RESET;
            end
        end
    end

    // Column address and read-modify-write
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            col_q <= lcd_cmd_pkg::COL_RESET;
            col_saved_q <= lcd_cmd_pkg::COL_RESET;
            rmw_q <= 1'b0;
        end else if (ce_in) begin
            if (cmd_wr) begin
                if (!cmd[7]) begin
                    col_q <= cmd[6:0];
                end
                if (cmd == lcd_cmd_pkg::OP_RMW) begin
                    col_saved_q <= col_q;
                    rmw_q <= 1'b1;
                end
                if (cmd == lcd_cmd_pkg::OP_END) begin
                    col_q <= col_saved_q;
                    rmw_q <= 1'b0;
                end
            end else if (dat_wr || (dat_rd && !rmw_q)) begin
                col_q <= col_inc;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            adc_out <= 1'b0;
            static_drive_out <= 1'b0;
            duty_32_out <= 1'b1;
            display_on_out <= 1'b0;
        end else if (ce_in && cmd_wr) begin
            case (cmd[7:1])
                lcd_cmd_pkg::OP_ADC_HI: adc_out <= cmd[0];
                lcd_cmd_pkg::OP_STATIC_HI: static_drive_out <= cmd[0];
                lcd_cmd_pkg::OP_DUTY_HI: duty_32_out <= cmd[0];
                lcd_cmd_pkg::OP_DISP_HI: display_on_out <= cmd[0];
                default: ;
            endcase
        end
    end

    // RAM write, no reset on storage
    always_ff @(posedge mclk_in) begin
        if (ce_in && dat_wr && col_q < lcd_cmd_pkg::COL_LIMIT) begin
            ram_q[ram_addr] <= bus.host_data;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            latch_q <= 8'h00;
            dout_q <= 8'h00;
            oe_q <= 1'b0;
        end else if (ce_in) begin
            oe_q <= dat_rd || st_rd;
            if (dat_rd) begin
                dout_q <= latch_q;
                latch_q <= (col_q < lcd_cmd_pkg::COL_LIMIT) ? ram_q[ram_addr] : 8'h00;
            end else if (st_rd) begin
                dout_q <= {busy_q, !adc_out, !display_on_out, in_reset, 4'h0};
            end
        end
    end
    assign bus.dev_data = dout_q;
    assign bus.dev_data_oe = oe_q;
endmodule : lcd_ram_command_decoder

// File: common/lcd_cmd_pkg.sv
// Constants and types shared by the LCD command decoder ends
package lcd_cmd_pkg;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 2;
    localparam int COL_W = 7;
    localparam int LINE_W = 5;
    localparam int NUM_PAGES = 4;
    localparam int NUM_COLS = 80;
    localparam logic [COL_W-1:0] COL_LIMIT = 7'h50;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 2'h3;
    localparam logic [PAGE_W-1:0] PAGE_HW_RESET = 2'h0;
    localparam logic [COL_W-1:0] COL_RESET = 7'h00;
    localparam logic [LINE_W-1:0] LINE_RESET = 5'h00;
    // Opcodes, full byte or upper bits as matched
    localparam logic [5:0] OP_PAGE_HI = 6'h2E;
    localparam logic [2:0] OP_LINE_HI = 3'h6;
    localparam logic [6:0] OP_ADC_HI = 7'h50;
    localparam logic [6:0] OP_STATIC_HI = 7'h52;
    localparam logic [6:0] OP_DUTY_HI = 7'h54;
    localparam logic [6:0] OP_DISP_HI = 7'h57;
    localparam logic [7:0] OP_RMW = 8'hE0;
    localparam logic [7:0] OP_END = 8'hEE;
    localparam logic [7:0] OP_SWRESET = 8'hE2;
    // Status byte bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_ADC = 6;
    localparam int ST_OFF = 5;
    localparam int ST_RESET = 4;
    // Cycles a software reset keeps busy and reset flags up
    localparam int SWRESET_CYCLES = 4;
    localparam logic [2:0] SWRESET_CNT = 3'(SWRESET_CYCLES);
    // Host command port codes
    localparam logic [1:0] HC_CMD = 2'h0;
    localparam logic [1:0] HC_STATUS = 2'h1;
    localparam logic [1:0] HC_WDATA = 2'h2;
    localparam logic [1:0] HC_RDATA = 2'h3;
    typedef enum logic [1:0] {IDLE, STROBE, DONE} host_state_t;
endpackage : lcd_cmd_pkg

// File: common/lcd_bus_if.sv
// Parallel host bus between host and LCD command decoder
`timescale 1ns/1ps
interface lcd_bus_if;
    logic strobe;
    logic register_select;
    logic read_not_write;
    logic [7:0] host_data;
    logic [7:0] dev_data;
    logic dev_data_oe;
    modport device (input strobe, input register_select, input read_not_write, input host_data,
        output dev_data, output dev_data_oe);
    modport host (output strobe, output register_select, output read_not_write, output host_data,
        input dev_data, input dev_data_oe);
endinterface : lcd_bus_if

// File: hdl/lcd_host_master.sv
// Host end: register port to parallel LCD bus transfers
`timescale 1ns/1ps
module lcd_host_master (
    // Clock, reset, enable
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // Software port
    input wire logic [1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // LCD bus
    lcd_bus_if.host bus
);
    logic [7:0] last_q;
    logic strobe_q;
    logic rs_q;
    logic rnw_q;
    logic [7:0] hd_q;
    logic cap_q;

    // software orders dummy reads, duty and command use
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            strobe_q <= 1'b0;
            rs_q <= 1'b0;
            rnw_q <= 1'b0;
            hd_q <= 8'h00;
        end else if (ce_in) begin
            strobe_q <= wr_in || rd_in;
            rs_q <= addr_in[1];
            rnw_q <= rd_in;
            hd_q <= wdata_in;
        end
    end

    // Capture answer one cycle after device latches it
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cap_q <= 1'b0;
            last_q <= 8'h00;
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            cap_q <= strobe_q && rnw_q;
            if (bus.dev_data_oe && cap_q) begin
                last_q <= bus.dev_data;
            end
            rdata_out <= (bus.dev_data_oe && cap_q) ? bus.dev_data : last_q;
        end
    end
    assign bus.strobe = strobe_q;
    assign bus.register_select = rs_q;
    assign bus.read_not_write = rnw_q;
    assign bus.host_data = hd_q;
endmodule : lcd_host_master

// File: tb/lcd_ram_command_decoder_props.sv
// Checks on the host bus and settings outputs of the LCD decoder
`timescale 1ns/1ps
module lcd_ram_command_decoder_props (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Bus and settings
    input wire logic strobe,
    input wire logic register_select,
    input wire logic read_not_write,
    input wire logic [7:0] host_data,
    input wire logic [7:0] dev_data,
    input wire logic dev_data_oe,
    input wire logic [4:0] start_line_out,
    input wire logic adc_out,
    input wire logic display_on_out,
    input wire logic static_drive_out,
    input wire logic duty_32_out,
    input wire logic busy_out
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);
    logic rd_go;
    logic cmd_go;
    // Enable tied high here, so every strobe is taken except a command while busy
    assign rd_go = strobe && read_not_write;
    assign cmd_go = strobe && !register_select && !read_not_write && !busy_out;
    a_oe_on_read: assert property (rd_go |=> dev_data_oe)
        else $error("no enable after read");
    a_oe_idle: assert property (!rd_go |=> !dev_data_oe)
        else $error("stray output enable");
    a_status_bits: assert property (rd_go && !register_select |=>
        dev_data[6:5] == {!adc_out, !display_on_out} && dev_data[3:0] == 4'h0)
        else $error("bad status byte");
    a_adc_set: assert property (cmd_go && host_data[7:1] == 7'h50 |=> adc_out == $past(host_data[0]))
        else $error("mapping not set");
    a_static_set: assert property (cmd_go && host_data[7:1] == 7'h52 |=> static_drive_out == $past(host_data[0]))
        else $error("static drive not set");
    a_duty_set: assert property (cmd_go && host_data[7:1] == 7'h54 |=> duty_32_out == $past(host_data[0]))
        else $error("duty not set");
    a_disp_set: assert property (cmd_go && host_data[7:1] == 7'h57 |=> display_on_out == $past(host_data[0]))
        else $error("display flag not set");
    a_line_set: assert property (cmd_go && host_data[7:5] == 3'h6 |=> start_line_out == $past(host_data[4:0]))
        else $error("start line not loaded");
    a_soft_reset: assert property (cmd_go && host_data == 8'hE2 |=> start_line_out == 5'h00 ##[0:2] busy_out)
        else $error("soft reset missed");
    a_cmd_refused: assert property (strobe && !register_select && !read_not_write && busy_out |=>
        $stable({start_line_out, adc_out, display_on_out, static_drive_out, duty_32_out}))
        else $error("command taken while busy");
endmodule : lcd_ram_command_decoder_props

// File: tb/lcd_ram_command_decoder_test.sv
// Bench joining host and device ends, checked against a behavioural model
`timescale 1ns/1ps
module lcd_ram_command_decoder_test;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [1:0] addr_in = 2'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic [4:0] start_line_out;
    logic adc_out, display_on_out, static_drive_out, duty_32_out, busy_out;
    int failures = 0;
    int cmp_count = 0;
    integer seed = 32'h3E19;
    // Model; -1 marks a byte never written, so its value is not judged
    int ram [4][80];
    int page = 0, col = 0, sav = 0, lat = 0, line = 0, c;
    bit rmw = 0, adc = 0, on = 0, st = 0, duty = 1;
    logic [7:0] codes [12] = '{8'hA1, 8'hA5, 8'hA8, 8'hAF, 8'hD5, 8'hF3, 8'hAA, 8'hA0, 8'hA4, 8'hA9, 8'hAE, 8'hDF};
    lcd_bus_if bus_w ();
    always #4 mclk_in = ~mclk_in;
    lcd_host_master u_lcd_host_master (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(1'b1), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .bus(bus_w));
    lcd_ram_command_decoder u_lcd_ram_command_decoder (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(1'b1),
        .bus(bus_w), .start_line_out(start_line_out), .adc_out(adc_out), .display_on_out(display_on_out),
        .static_drive_out(static_drive_out), .duty_32_out(duty_32_out), .busy_out(busy_out));
    lcd_ram_command_decoder_props u_props (.mclk_in(mclk_in), .nrst_in(nrst_in), .strobe(bus_w.strobe),
        .register_select(bus_w.register_select), .read_not_write(bus_w.read_not_write),
        .host_data(bus_w.host_data), .dev_data(bus_w.dev_data), .dev_data_oe(bus_w.dev_data_oe),
        .start_line_out(start_line_out), .adc_out(adc_out), .display_on_out(display_on_out),
        .static_drive_out(static_drive_out), .duty_32_out(duty_32_out), .busy_out(busy_out));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Host port is not pipelined here: one request, then room for the answer
    task automatic op(input logic [1:0] a, input logic [7:0] d, input logic r);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= !r;
        rd_in <= r;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        // Three edges: read answer is in rdata_out, and a next request still meets the reset busy time
        repeat (3) @(posedge mclk_in);
    endtask : op
    task automatic cmd(input logic [7:0] d);
        op(2'h0, d, 1'b0);
        if (!d[7]) col = d[6:0];
        else if (d[7:2] == 6'h2E) page = d[1:0];
        else if (d[7:5] == 3'h6) line = d[4:0];
        else if (d[7:1] == 7'h50) adc = d[0];
        else if (d[7:1] == 7'h52) st = d[0];
        else if (d[7:1] == 7'h54) duty = d[0];
        else if (d[7:1] == 7'h57) on = d[0];
        else if (d == 8'hE0) begin
            rmw = 1;
            sav = col;
        end else if (d == 8'hEE) begin
            rmw = 0;
            col = sav;
        end else if (d == 8'hE2) begin
            line = 0;
            page = 3;
            // Status read lands inside the reset busy time
            op(2'h0, 8'h00, 1'b1);
            chk("busy status", {8'h00, 1'b1, !adc, !on, 1'b1, 4'h0}, {8'h00, rdata_out});
        end
        chk("settings", {7'h00, 5'(line), adc, on, st, duty},
            {7'h00, start_line_out, adc_out, display_on_out, static_drive_out, duty_32_out});
        op(2'h0, 8'h00, 1'b1);
        chk("status", {9'h000, !adc, !on, 5'h00}, {8'h00, rdata_out});
    endtask : cmd
    task automatic wd(input logic [7:0] d);
        op(2'h2, d, 1'b0);
        if (col < 80) begin
            ram[page][col] = d;
            col++;
        end
    endtask : wd
    task automatic rdd();
        op(2'h3, 8'h00, 1'b1);
        if (lat >= 0) chk("rdata", 16'(lat), {8'h00, rdata_out});
        lat = (col < 80) ? ram[page][col] : 0;
        if (col < 80 && !rmw) col++;
    endtask : rdd
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    initial begin
        #200000;
        failures++;
        conclude();
    end
    initial begin
        foreach (ram[i, j]) ram[i][j] = -1;
        repeat (5) @(posedge mclk_in);
        nrst_in <= 1'b1;
        foreach (codes[i]) cmd(codes[i]);
        // Page 3 starts at 76 so the column runs into its stop at 80
        for (int p = 3; p >= 0; p--) begin
            c = (p == 3) ? 76 : $unsigned($random(seed)) % 70;
            cmd(8'hB8 | 8'(p));
            cmd(8'(c));
            repeat (6) wd(8'($random(seed)));
            cmd(8'(c));
            rdd();
            repeat (6) rdd();
        end
        cmd(8'hE2);
        // Command issued inside the reset busy time must be dropped
        op(2'h0, 8'hE2, 1'b0);
        op(2'h0, {7'h50, !adc}, 1'b0);
        chk("refused", {15'h0000, adc}, {15'h0000, adc_out});
        cmd(8'h4C);
        rdd();
        cmd(8'hE0);
        rdd();
        rdd();
        wd(8'h5A);
        cmd(8'hEE);
        repeat (3) rdd();
        conclude();
    end
endmodule : lcd_ram_command_decoder_test
